// file: src/phr_high_region.sv
`timescale 1ns/10ps
`include "phr_params.svh"
module phr_high_region #(
  parameter int HAW_BITS  = 48,
  parameter int RSVD_BITS = 20,
  parameter bit SUPPORTED = 1'b1
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // DMA request check
  input  wire phr_pkg::phr_dma_req_t dma_req,
  output phr_pkg::phr_dma_rsp_t      dma_rsp,
  // Protection state
  output logic                       protect_active
);
  import phr_pkg::*;

  // Limitations: only the high region is kept here, and a refused write leaves
  // no trace but the unchanged read-back. Software that needs to know whether a
  // write landed must read the word back.

  // Elaboration checks: the region must be able to reach above 4GB, and at
  // least one reserved low bit must exist, or the granule decode collapses.
  generate
    if (HAW_BITS < 33 || HAW_BITS > 64) begin : g_bad_haw
      $error("HAW_BITS must lie in 33..64");
    end
    if (RSVD_BITS < 1 || RSVD_BITS >= HAW_BITS) begin : g_bad_rsvd
      $error("RSVD_BITS must lie in 1..HAW_BITS-1");
    end
  endgenerate

  // Bits kept in flops: between the reserved low bits and the address width.
  function automatic logic [63:0] impl_mask();
    logic [63:0] m;
    m = '0;
    for (int i = 0; i < 64; i++) begin
      if (i > RSVD_BITS - 1 && i < HAW_BITS)
        m[i] = 1'b1;
    end
    return m;
  endfunction

  function automatic logic [63:0] low_ones();
    logic [63:0] m;
    m = '0;
    for (int i = 0; i < 64; i++) begin
      if (i < RSVD_BITS)
        m[i] = 1'b1;
    end
    return m;
  endfunction

  localparam logic [63:0] IMPL_MASK = impl_mask();
  localparam logic [63:0] LOW_ONES  = low_ones();
  // Every address bit below the address width, reserved or not.
  localparam logic [63:0] ADDR_MASK = IMPL_MASK | LOW_ONES;

  logic [63:0]    high_region_base_reg;
  logic [63:0]    high_region_limit_reg;
  logic           protect_enable_reg;
  logic           protect_region_status;
  logic           block_seen;
  phr_bus_state_t bus_state;
  phr_bus_state_t next_bus_state;
  logic           setup_cyc;
  logic           wr_go;
  logic           rd_go;
  logic           wr_base_lo;
  logic           wr_base_hi;
  logic           wr_limit_lo;
  logic           wr_limit_hi;
  logic           wr_ctrl;
  logic           wr_stat;
  logic           wr_open;
  logic [63:0]    dma_addr;
  logic           hit_now;
  logic           reg_hit;
  logic [31:0]    next_prdata;
  logic           high_region_supported;
  logic [63:0]    dec_base;
  logic [63:0]    dec_limit;
  logic           region_on;
  logic           in_region;

  assign high_region_supported = SUPPORTED;

  function automatic logic addr_known(input logic [11:0] a);
    logic hit;
    case (a)
      `PHR_OFF_BASE_LO,
      `PHR_OFF_BASE_HI,
      `PHR_OFF_LIMIT_LO,
      `PHR_OFF_LIMIT_HI,
      `PHR_OFF_CTRL,
      `PHR_OFF_STAT: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // Inclusive window test shared by the response and the sticky record.
  function automatic logic in_window(input logic [63:0] a,
                                     input logic [63:0] lo,
                                     input logic [63:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // Merge one 32-bit word into a 64-bit register, keeping only implemented bits.
  function automatic logic [63:0] merge_word(input logic [63:0] cur,
                                            input logic        hi,
                                            input logic [31:0] w);
    logic [63:0] n;
    n = cur;
    if (hi)
      n[63:32] = w;
    else
      n[31:0] = w;
    return n & IMPL_MASK;
  endfunction

  // APB slave: setup, then one wait-free access cycle answered with pready.
  // A setup seen while an access is still being answered cannot come from a
  // legal master, so it is not taken.
  always_comb begin
    next_bus_state = PHR_IDLE;
    case (bus_state)
      PHR_IDLE: begin
        if (setup_cyc) begin
          next_bus_state = PHR_ACCESS;
        end
      end
      PHR_ACCESS: begin
        next_bus_state = PHR_DONE;
      end
      PHR_DONE: begin
        if (setup_cyc) begin
          next_bus_state = PHR_ACCESS;
        end
      end
      default: begin
        next_bus_state = PHR_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state <= PHR_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // The answer is computed in the setup cycle and shown with pready in access.
  assign setup_cyc = psel && !penable;
  assign reg_hit   = addr_known(paddr);
  assign wr_go     = psel && penable && pready && pwrite;
  assign rd_go     = setup_cyc && !pwrite;

  // One strobe per word, so the register processes carry no address decode.
  assign wr_base_lo  = wr_go && (paddr == `PHR_OFF_BASE_LO);
  assign wr_base_hi  = wr_go && (paddr == `PHR_OFF_BASE_HI);
  assign wr_limit_lo = wr_go && (paddr == `PHR_OFF_LIMIT_LO);
  assign wr_limit_hi = wr_go && (paddr == `PHR_OFF_LIMIT_HI);
  assign wr_ctrl     = wr_go && (paddr == `PHR_OFF_CTRL);
  assign wr_stat     = wr_go && (paddr == `PHR_OFF_STAT);
  // Base and limit writes while the status flag is set are dropped as a safety net, so a
  // misbehaving driver cannot move an armed region.
  assign wr_open     = high_region_supported && !protect_region_status;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= next_bus_state == PHR_ACCESS;
      pslverr <= (next_bus_state == PHR_ACCESS) && !reg_hit;
    end
  end

  always_comb begin
    next_prdata = `PHR_RST_WORD;
    case (paddr)
      `PHR_OFF_BASE_LO:  next_prdata = high_region_base_reg[31:0];
      `PHR_OFF_BASE_HI:  next_prdata = high_region_base_reg[63:32];
      `PHR_OFF_LIMIT_LO: next_prdata = high_region_limit_reg[31:0];
      `PHR_OFF_LIMIT_HI: next_prdata = high_region_limit_reg[63:32];
      `PHR_OFF_CTRL:     next_prdata[`PHR_CTRL_EN_BIT] = protect_enable_reg;
      `PHR_OFF_STAT: begin
        next_prdata[`PHR_STAT_PRS_BIT] = protect_region_status;
        next_prdata[`PHR_STAT_SUP_BIT] = high_region_supported;
        next_prdata[`PHR_STAT_ON_BIT]  = region_on;
        next_prdata[`PHR_STAT_BLK_BIT] = block_seen;
      end
      default:           next_prdata = `PHR_RST_WORD;
    endcase
  end

  // Read data stands only in the access cycle and returns to zero after it,
  // so a stale word never looks like an answer to the next transfer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `PHR_RST_WORD;
    end else if (rd_go) begin
      prdata <= next_prdata;
    end else begin
      prdata <= `PHR_RST_WORD;
    end
  end

  // Base register; each half is written on its own word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_region_base_reg <= `PHR_RST_REG;
    end else if (wr_open) begin
      if (wr_base_lo) begin
        high_region_base_reg <= merge_word(high_region_base_reg, 1'b0, pwdata);
      end else if (wr_base_hi) begin
        high_region_base_reg <= merge_word(high_region_base_reg, 1'b1, pwdata);
      end
    end
  end

  // Limit register; the halves are independent, like the base.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_region_limit_reg <= `PHR_RST_REG;
    end else if (wr_open) begin
      if (wr_limit_lo) begin
        high_region_limit_reg <= merge_word(high_region_limit_reg, 1'b0, pwdata);
      end else if (wr_limit_hi) begin
        high_region_limit_reg <= merge_word(high_region_limit_reg, 1'b1, pwdata);
      end
    end
  end

  // Protection enable, written by software once the region is set up.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protect_enable_reg <= 1'b0;
    end else if (wr_ctrl) begin
      protect_enable_reg <= pwdata[`PHR_CTRL_EN_BIT];
    end
  end

  // The status flag lags the enable by one cycle, so checks never start in the
  // same cycle as the write that arms them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protect_region_status <= 1'b0;
    end else begin
      protect_region_status <= protect_enable_reg;
    end
  end

  // Decode: full 64-bit compare, so the region may sit on either side of 4GB.
  assign dec_base  = high_region_base_reg & ~LOW_ONES;
  assign dec_limit = high_region_limit_reg | LOW_ONES;
  assign region_on = high_region_supported &&
                     !(high_region_limit_reg < high_region_base_reg);
  // Address bits above the width never reach memory; dropping them before the
  // compare blocks aliases of the region rather than letting them through.
  assign dma_addr  = dma_req.addr & ADDR_MASK;
  assign in_region = in_window(dma_addr, dec_base, dec_limit);
  assign hit_now   = dma_req.valid && protect_region_status && region_on && in_region;

  // DMA check answered one cycle after the request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_rsp <= '0;
    end else begin
      dma_rsp.valid   <= dma_req.valid;
      dma_rsp.blocked <= hit_now;
    end
  end

  // Sticky record of a blocked request; cleared by writing a one to PHR_STAT_BLK_BIT of the status word,
  // with a new block winning over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_seen <= 1'b0;
    end else if (hit_now) begin
      block_seen <= 1'b1;
    end else if (wr_stat && pwdata[`PHR_STAT_BLK_BIT]) begin
      block_seen <= 1'b0;
    end
  end

  // Protection is reported active only while the flag is set and the window is
  // not empty.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protect_active <= 1'b0;
    end else begin
      protect_active <= protect_region_status && region_on;
    end
  end
endmodule

// file: src/phr_params.svh
`ifndef PHR_PARAMS_SVH
`define PHR_PARAMS_SVH
// Register byte offsets; each 64-bit register spans two 32-bit words.
`define PHR_OFF_BASE_LO   12'h070
`define PHR_OFF_BASE_HI   12'h074
`define PHR_OFF_LIMIT_LO  12'h078
`define PHR_OFF_LIMIT_HI  12'h07C
`define PHR_OFF_CTRL      12'h0C0
`define PHR_OFF_STAT      12'h0C4
// Control register fields.
`define PHR_CTRL_EN_BIT   0
// Status register fields.
`define PHR_STAT_PRS_BIT  0
`define PHR_STAT_SUP_BIT  1
`define PHR_STAT_ON_BIT   2
`define PHR_STAT_BLK_BIT  3
// Reset values.
`define PHR_RST_WORD      32'h0000_0000
`define PHR_RST_REG       64'h0000_0000_0000_0000
`define PHR_ADDR_BITS     12
`endif

// file: src/phr_pkg.sv
package phr_pkg;
  typedef struct packed {
    logic        valid;
    logic [63:0] addr;
  } phr_dma_req_t;
  typedef struct packed {
    logic        valid;
    logic        blocked;
  } phr_dma_rsp_t;
  typedef enum logic [2:0] {
    PHR_IDLE   = 3'b001,
    PHR_ACCESS = 3'b010,
    PHR_DONE   = 3'b100
  } phr_bus_state_t;
endpackage

// file: tb/phr_dma_src.sv
`timescale 1ns/10ps
module phr_dma_src (
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // Command from the bench
  input wire logic              go,
  input wire logic [63:0]       go_addr,
  // Request toward the block
  output phr_pkg::phr_dma_req_t dma_req
);
  import phr_pkg::*;
  // An idle address keeps toggling so a stale value never looks like a request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_req <= '0;
    end else begin
      dma_req.valid <= go;
      dma_req.addr  <= go ? go_addr : ~dma_req.addr;
    end
  end
endmodule

// file: tb/phr_high_region_monitor.sv
`timescale 1ns/10ps
module phr_high_region_monitor #(
  parameter int HAW_BITS  = 48,
  parameter int RSVD_BITS = 20
) (
  // Clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // APB
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // DMA check and state
  input wire phr_pkg::phr_dma_req_t dma_req,
  input wire phr_pkg::phr_dma_rsp_t dma_rsp,
  input wire logic                  protect_active
);
  import phr_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire map_hit = paddr inside {12'h070, 12'h074, 12'h078, 12'h07C, 12'h0C0, 12'h0C4};
  wire rd_cyc  = pready && !pwrite;
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  a_ready_only_access: assert property (pready |-> $past(psel && !penable))
    else $error("pready without a setup cycle");
  a_err_unmapped: assert property (pready |-> pslverr == !map_hit)
    else $error("pslverr does not match the map");
  a_idle_data_zero: assert property (!rd_cyc || pslverr |-> prdata == 32'h0)
    else $error("prdata not zero outside a mapped read");
  a_low_rsvd_zero: assert property (
    rd_cyc && paddr inside {12'h070, 12'h078} |-> prdata[RSVD_BITS-1:0] == '0)
    else $error("reserved low bits read back nonzero");
  a_high_unimpl_zero: assert property (
    rd_cyc && paddr inside {12'h074, 12'h07C} |-> prdata[31:HAW_BITS-32] == '0)
    else $error("bits above address width read back nonzero");
  a_rsp_follows_req: assert property (dma_rsp.valid == $past(dma_req.valid))
    else $error("response not one cycle after request");
  a_block_needs_on: assert property (
    dma_rsp.blocked |-> protect_active || $past(protect_active))
    else $error("request blocked while protection off");
endmodule
bind phr_high_region phr_high_region_monitor #(.HAW_BITS(HAW_BITS), .RSVD_BITS(RSVD_BITS)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .dma_req(dma_req), .dma_rsp(dma_rsp), .protect_active(protect_active));

// file: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  import phr_pkg::*;
  localparam int H = 48;
  localparam int R = 20;
  localparam logic [63:0] B  = 64'h0000_0001_0030_0000;
  localparam logic [63:0] M  = (64'h1 << R) - 64'h1;
  localparam logic [31:0] LO = 32'hFFFF_FFFF << R;
  localparam logic [31:0] HI = ~(32'hFFFF_FFFF << (H - 32));
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, protect_active, go = 1'b0;
  logic [63:0] ga = 64'h0;
  phr_dma_req_t dma_req;
  phr_dma_rsp_t dma_rsp;
  int n_fail = 0, n_checks = 0;
  always #25 pclk = ~pclk;
  phr_high_region #(.HAW_BITS(H), .RSVD_BITS(R), .SUPPORTED(1'b1)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_req(dma_req), .dma_rsp(dma_rsp), .protect_active(protect_active));
  phr_dma_src u_src (.pclk(pclk), .presetn(presetn), .go(go), .go_addr(ga), .dma_req(dma_req));
  task chk(input string s, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  // Request held from setup until pready is seen high at an edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input string s, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(s, e, rd);
    chk("slverr", 0, er);
  endtask
  task set_regs(input logic [63:0] b, input logic [63:0] l);
    apb(1'b1, 12'h070, b[31:0]);
    apb(1'b1, 12'h074, b[63:32]);
    apb(1'b1, 12'h078, l[31:0]);
    apb(1'b1, 12'h07C, l[63:32]);
  endtask
  task dma(input logic [63:0] a, input logic b);
    @(posedge pclk);
    go <= 1'b1;
    ga <= a;
    @(posedge pclk);
    go <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("rsp_valid", 1, dma_rsp.valid);
    chk("blocked", b, dma_rsp.blocked);
  endtask
  task t_reset;
    for (int i = 0; i < 4; i++) rdc("reset", 12'h070 + 12'(4 * i), 32'h0);
    apb(1'b0, 12'h100, 32'hFFFF_FFFF);
    chk("unmapped_err", 1, er);
    chk("unmapped_data", 0, rd);
    $display("test reset done");
  endtask
  task t_probe;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h070 + 12'(4 * i), 32'hFFFF_FFFF);
      rdc("probe", 12'h070 + 12'(4 * i), i[0] ? HI : LO);
    end
    $display("test probe done");
  endtask
  task t_region;
    set_regs(B, B);
    apb(1'b1, 12'h0C0, 32'h1);
    for (int k = 0; k < 8 && protect_active !== 1'b1; k++) @(posedge pclk);
    chk("active", 1, protect_active);
    dma(B - 64'h1, 0);
    dma(B, 1);
    dma(B + M, 1);
    dma(B + M + 64'h1, 0);
    rdc("status", 12'h0C4, 32'hF);
    apb(1'b1, 12'h0C4, 32'h8);
    rdc("blk_clear", 12'h0C4, 32'h7);
    apb(1'b1, 12'h070, 32'h0);
    rdc("locked", 12'h070, B[31:0]);
    $display("test region done");
  endtask
  task t_empty;
    apb(1'b1, 12'h0C0, 32'h0);
    repeat (4) @(posedge pclk);
    set_regs(B, B - 64'h10_0000);
    apb(1'b1, 12'h0C0, 32'h1);
    repeat (4) @(posedge pclk);
    chk("active", 0, protect_active);
    dma(B, 0);
    $display("test empty done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_probe;
    t_region;
    t_empty;
    wrap_up;
  end
  initial begin
    repeat (3000) @(posedge pclk);
    n_fail++;
    wrap_up;
  end
endmodule
